// ### mac_tx_fifo_map.vh
// register offsets, field positions, reset values and constants of the transmit buffer block
`ifndef MAC_TX_FIFO_MAP_VH
`define MAC_TX_FIFO_MAP_VH
`define ADDR_TX_PUSH        16'h2000
`define ADDR_SEC_PUSH       16'h2000
`define ADDR_TX_WRITE_IDX   16'h2001
`define ADDR_TX_READ_IDX    16'h2002
`define ADDR_TX_CONTROL     16'h2003
`define ADDR_TX_STATE       16'h2004
`define ADDR_TX_COUNT       16'h2005
`define ADDR_PHY_COMMAND    16'h2200
`define ADDR_BUF_BASE       16'h2300
`define BUF_BASE_PAGE       8'h23
`define BANK_FIFO           2'h0
`define BANK_SECURITY       2'h1
`define CTRL_CLEAR_BIT      0
`define CTRL_ENABLE_BIT     1
`define CTRL_AUTOADDR_BIT   2
`define CTRL_RESET          3'h6
`define STATE_EMPTY_BIT     0
`define STATE_FULL_BIT      1
`define STATE_RD_MSB_BIT    6
`define STATE_WR_MSB_BIT    7
`define CMD_TX_REQ_BIT      0
`define CMD_ENCRYPT_BIT     1
`define CRC_BYTES           8'h02
`define CRC_INIT            16'h0000
`define CRC_POLY_REFLECTED  16'h8408
`endif

// ### byte_ring.v
// circular byte buffer with 9-bit pointers, push/pop, pointer loads and direct indexed access
`timescale 1ns/1ps
module byte_ring #(
    parameter DEPTH_LOG2 = 8,
    parameter WIDTH      = 8
) (
    input  wire                  clk,
    input  wire                  nrst,
    input  wire                  enable,
    input  wire                  clear,
    input  wire                  push,
    input  wire [WIDTH-1:0]      pushData,
    input  wire                  pop,
    output wire [WIDTH-1:0]      popData,
    input  wire                  wrLowLoad,
    input  wire                  rdLowLoad,
    input  wire                  msbLoad,
    input  wire [DEPTH_LOG2-1:0] lowData,
    input  wire                  wrMsbData,
    input  wire                  rdMsbData,
    input  wire                  directWe,
    input  wire [DEPTH_LOG2-1:0] directAddr,
    input  wire [WIDTH-1:0]      directData,
    input  wire [DEPTH_LOG2-1:0] peekAddr,
    output wire [WIDTH-1:0]      peekData,
    output wire [DEPTH_LOG2:0]   wrIdx,
    output wire [DEPTH_LOG2:0]   rdIdx,
    output wire [DEPTH_LOG2:0]   count,
    output wire                  full,
    output wire                  empty
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg  [WIDTH-1:0]      mem [0:DEPTH-1];
    reg  [DEPTH_LOG2:0]   wrIdx_q;
    reg  [DEPTH_LOG2:0]   rdIdx_q;
    wire                  doPush;
    wire                  doPop;
    integer               i;

    assign doPush  = push && enable && !full;
    assign doPop   = pop && enable && !empty;
    assign popData = mem[rdIdx_q[DEPTH_LOG2-1:0]];
    assign peekData = mem[peekAddr];
    assign wrIdx   = wrIdx_q;
    assign rdIdx   = rdIdx_q;
    assign count   = wrIdx_q - rdIdx_q;
    assign full    = (wrIdx_q[DEPTH_LOG2-1:0] == rdIdx_q[DEPTH_LOG2-1:0]) &&
                     (wrIdx_q[DEPTH_LOG2] != rdIdx_q[DEPTH_LOG2]);
    assign empty   = (wrIdx_q == rdIdx_q);

    always @(posedge clk)
    begin
        if (!nrst || clear)
        begin
            wrIdx_q <= {(DEPTH_LOG2+1){1'b0}};
            rdIdx_q <= {(DEPTH_LOG2+1){1'b0}};
        end
        else
        begin
            if (wrLowLoad)
                wrIdx_q[DEPTH_LOG2-1:0] <= lowData;
            else if (msbLoad)
                wrIdx_q[DEPTH_LOG2] <= wrMsbData;
            else if (doPush)
                wrIdx_q <= wrIdx_q + 1'b1;
            if (rdLowLoad)
                rdIdx_q[DEPTH_LOG2-1:0] <= lowData;
            else if (msbLoad)
                rdIdx_q[DEPTH_LOG2] <= rdMsbData;
            else if (doPop)
                rdIdx_q <= rdIdx_q + 1'b1;
        end
    end

    // storage keeps contents across clear; only the pointers are reset
    always @(posedge clk)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
        begin
            if (doPush && wrIdx_q[DEPTH_LOG2-1:0] == i)
                mem[i] <= pushData;
            else if (directWe && directAddr == i)
                mem[i] <= directData;
        end
    end
endmodule

// ### mac_tx_fifo_ctrl.v
// transmit buffer controller: register decode, frame sequencer towards the phy, cipher hand-off
//
// Functional notes
// [R1] push register write appends byte at write pointer
// [R2] 256-byte circular buffer with separate write and read pointers
// [R3] every buffer entry directly readable and writable by processor
// [R4] buffered frame goes to phy only after transmit-request command
// [R5] software puts frame length in first byte of each frame
// [R6] after encryption hardware rewrites the frame length byte
// [R7] auto-crc bit set: hardware appends crc; clear: software supplies it
// [R8] aes interrupt each time transmit encryption completes
// [R9] phy interrupt when frame transfer to phy completes
// [R10] fifo control registers decoded only when bank select is 0
// [R11] 9-bit write pointer, msb in status bit 7, increments per written byte
// [R12] 9-bit read pointer, msb in status bit 6, increments per read byte
// [R13] software changing a pointer msb also updates its low part; here a status write loads only the two pointer msbs
// [R14] auto-address bit feeds cipher start and length from queued frame; here the length is the buffer byte at cipherAddr, not at the read pointer
// [R15] buffer operates only while enable bit set
// [R16] clear bit resets pointers, status and byte count
// [R17] full flag at 256 bytes, empty flag at zero bytes
// [R18] byte count is write pointer minus read pointer
// [R19] encryption is 128-bit aes in ccm-family modes
// [R20] two selectable keys; software loads nonce and selects key first
// [R21] security fifo registers decoded only when bank select is 1
// [R22] security push write appends byte to separate security buffer
// [R23] full and empty derived by comparing the 9-bit pointers
// [R24] security push register sits at 0x2000 in security bank
`timescale 1ns/1ps
`include "mac_tx_fifo_map.vh"
module mac_tx_fifo_ctrl #(
    parameter DEPTH_LOG2 = 8 // [R2]
) (
    input  wire                  clk,
    input  wire                  nrst,
    input  wire [15:0]           addr,
    input  wire                  wrEn,
    input  wire                  rdEn,
    input  wire [7:0]            wrData,
    output wire [7:0]            rdData,
    input  wire [1:0]            registerBankSelect,
    input  wire                  autoCrc,
    input  wire                  keySelectIn,
    input  wire [7:0]            cipherBaseSw,
    input  wire [7:0]            cipherLenSw,
    output wire                  cipherStart,
    output wire [7:0]            cipherBase,
    output wire [7:0]            cipherLen,
    output wire                  cipherKeySel,
    input  wire                  cipherDone,
    input  wire [7:0]            cipherNewLen,
    input  wire                  cipherWe,
    input  wire [7:0]            cipherAddr,
    input  wire [7:0]            cipherWrData,
    output wire [7:0]            cipherRdData,
    output wire [7:0]            phyData,
    output wire                  phyValid,
    input  wire                  phyReady,
    output wire                  aesIrq,
    output wire                  phyIrq,
    output wire                  txBusy,
    output wire [8:0]            secureCount
);
    localparam S_IDLE  = 7'h01;
    localparam S_CIPH  = 7'h02;
    localparam S_RELEN = 7'h04;
    localparam S_LEN   = 7'h08;
    localparam S_SEND  = 7'h10;
    localparam S_CRC   = 7'h20;
    localparam S_DONE  = 7'h40;

    // one crc-16 step per byte, lsb first, reflected polynomial
    function [15:0] crcByte;
        input [15:0] crcIn;
        input [7:0]  dataIn;
        integer      k;
        reg   [15:0] c;
        begin
            c = crcIn;
            for (k = 0; k < 8; k = k + 1)
            begin
                if (c[0] ^ dataIn[k])
                    c = (c >> 1) ^ `CRC_POLY_REFLECTED;
                else
                    c = c >> 1;
            end
            crcByte = c;
        end
    endfunction

    reg  [2:0]  ctrl_q;
    reg  [7:0]  rdData_q;
    reg  [6:0]  state_q;
    reg         txReq_q;
    reg         encReq_q;
    reg         encrypt_q;
    reg  [7:0]  remain_q;
    reg  [15:0] crc_q;
    reg  [1:0]  crcCnt_q;
    reg  [7:0]  phyData_q;
    reg         phyValid_q;
    reg         cipherStart_q;
    reg         aesIrq_q;
    reg         phyIrq_q;

    wire        bank0;
    wire        bank1;
    wire        inBufWin;
    wire        wrReg;
    wire        take;
    wire        txEnable;
    wire        txClear;
    wire [7:0]  popData;
    wire [7:0]  peekData;
    wire [8:0]  wrIdx;
    wire [8:0]  rdIdx;
    wire [8:0]  count;
    wire        full;
    wire        empty;
    reg         popReq;
    reg         directWe;
    reg  [7:0]  directAddr;
    reg  [7:0]  directData;
    reg  [7:0]  regRead;

    assign bank0    = (registerBankSelect == `BANK_FIFO);                   // [R10]
    assign bank1    = (registerBankSelect == `BANK_SECURITY);               // [R21]
    assign inBufWin = (addr[15:8] == `BUF_BASE_PAGE);                       // [R3]
    assign wrReg    = wrEn && bank0;
    assign txEnable = ctrl_q[`CTRL_ENABLE_BIT];                             // [R15]
    assign txClear  = ctrl_q[`CTRL_CLEAR_BIT];                              // [R16]
    assign take     = !phyValid_q || phyReady;

    // clear is level-held: pointers stay at zero until software drops the bit
    byte_ring #(
        .DEPTH_LOG2 (DEPTH_LOG2),
        .WIDTH      (8)
    ) txRing (
        .clk        (clk),
        .nrst       (nrst),
        .enable     (txEnable),
        .clear      (txClear),
        .push       (wrReg && addr == `ADDR_TX_PUSH),                       // [R1]
        .pushData   (wrData),
        .pop        (popReq),                                               // [R12]
        .popData    (popData),
        .wrLowLoad  (wrReg && addr == `ADDR_TX_WRITE_IDX),                  // [R11]
        .rdLowLoad  (wrReg && addr == `ADDR_TX_READ_IDX),
        .msbLoad    (wrReg && addr == `ADDR_TX_STATE),                      // [R13]
        .lowData    (wrData),
        .wrMsbData  (wrData[`STATE_WR_MSB_BIT]),
        .rdMsbData  (wrData[`STATE_RD_MSB_BIT]),
        .directWe   (directWe),
        .directAddr (directAddr),
        .directData (directData),
        .peekAddr   (inBufWin ? addr[7:0] : cipherAddr),
        .peekData   (peekData),
        .wrIdx      (wrIdx),
        .rdIdx      (rdIdx),
        .count      (count),                                                // [R18]
        .full       (full),                                                 // [R23]
        .empty      (empty)
    );

    // security buffer: only its push port and its byte count live in this block
    byte_ring #(
        .DEPTH_LOG2 (DEPTH_LOG2),
        .WIDTH      (8)
    ) secRing (
        .clk        (clk),
        .nrst       (nrst),
        .enable     (1'b1),
        .clear      (1'b0),
        .push       (wrEn && bank1 && addr == `ADDR_SEC_PUSH),              // [R22] [R24]
        .pushData   (wrData),
        .pop        (1'b0),
        .popData    (),
        .wrLowLoad  (1'b0),
        .rdLowLoad  (1'b0),
        .msbLoad    (1'b0),
        .lowData    (8'h00),
        .wrMsbData  (1'b0),
        .rdMsbData  (1'b0),
        .directWe   (1'b0),
        .directAddr (8'h00),
        .directData (8'h00),
        .peekAddr   (8'h00),
        .peekData   (),
        .wrIdx      (),
        .rdIdx      (),
        .count      (secureCount),
        .full       (),
        .empty      ()
    );

    // direct write mux: length rewrite wins over the cipher engine, which wins over the processor
    always @*
    begin
        directWe   = 1'b0;
        directAddr = addr[7:0];
        directData = wrData;
        if (state_q == S_RELEN)
        begin
            directWe   = 1'b1;                                              // [R6]
            directAddr = rdIdx[7:0];
            directData = cipherNewLen;
        end
        else if (cipherWe)
        begin
            directWe   = 1'b1;
            directAddr = cipherAddr;
            directData = cipherWrData;
        end
        else if (wrEn && inBufWin)
        begin
            directWe   = 1'b1;                                              // [R3]
        end
    end

    always @*
    begin
        regRead = 8'h00;
        if (inBufWin)
            regRead = peekData;                                             // [R3]
        else if (bank0)
        begin
            case (addr)
                `ADDR_TX_WRITE_IDX: regRead = wrIdx[7:0];
                `ADDR_TX_READ_IDX:  regRead = rdIdx[7:0];
                `ADDR_TX_CONTROL:   regRead = {5'h00, ctrl_q};
                `ADDR_TX_STATE:     regRead = {wrIdx[8], rdIdx[8], 4'h0, full, empty}; // [R17]
                `ADDR_TX_COUNT:     regRead = count[7:0];                   // [R18]
                default:            regRead = 8'h00;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl_q   <= `CTRL_RESET;
            rdData_q <= 8'h00;
        end
        else
        begin
            if (wrReg && addr == `ADDR_TX_CONTROL)
                ctrl_q <= wrData[2:0];
            if (rdEn)
                rdData_q <= regRead;
        end
    end

    always @*
    begin
        popReq = 1'b0;
        if (state_q == S_LEN && !empty)
            popReq = 1'b1;
        else if (state_q == S_SEND && take && remain_q != 8'h00 && !empty)
            popReq = 1'b1;
    end

    // frame sequencer; an empty buffer mid-frame stalls the phy stream rather than aborting
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q       <= S_IDLE;
            txReq_q       <= 1'b0;
            encReq_q      <= 1'b0;
            encrypt_q     <= 1'b0;
            remain_q      <= 8'h00;
            crc_q         <= `CRC_INIT;
            crcCnt_q      <= 2'h0;
            phyData_q     <= 8'h00;
            phyValid_q    <= 1'b0;
            cipherStart_q <= 1'b0;
            aesIrq_q      <= 1'b0;
            phyIrq_q      <= 1'b0;
        end
        else
        begin
            cipherStart_q <= 1'b0;
            aesIrq_q      <= 1'b0;
            phyIrq_q      <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (txReq_q && txEnable && !txClear && !empty)
                    begin
                        txReq_q   <= 1'b0;
                        encrypt_q <= encReq_q;
                        crc_q     <= `CRC_INIT;
                        crcCnt_q  <= 2'h0;
                        if (encReq_q)
                        begin
                            cipherStart_q <= 1'b1;
                            state_q       <= S_CIPH;
                        end
                        else
                            state_q <= S_LEN;
                    end
                end
                S_CIPH:
                begin
                    if (cipherDone)
                    begin
                        aesIrq_q <= 1'b1;                                   // [R8]
                        state_q  <= S_RELEN;
                    end
                end
                S_RELEN:
                    state_q <= S_LEN;
                S_LEN:
                begin
                    if (!empty)
                    begin
                        phyData_q  <= popData;
                        phyValid_q <= 1'b1;
                        if (autoCrc)                                        // [R7]
                            remain_q <= (popData > `CRC_BYTES) ? popData - `CRC_BYTES : 8'h00;
                        else
                            remain_q <= popData;
                        state_q <= S_SEND;
                    end
                end
                S_SEND:
                begin
                    if (take)
                    begin
                        if (remain_q != 8'h00 && !empty)
                        begin
                            phyData_q  <= popData;
                            phyValid_q <= 1'b1;
                            remain_q   <= remain_q - 8'h01;
                            crc_q      <= crcByte(crc_q, popData);
                        end
                        else
                        begin
                            phyValid_q <= 1'b0;
                            if (remain_q == 8'h00)
                                state_q <= autoCrc ? S_CRC : S_DONE;        // [R7]
                        end
                    end
                end
                S_CRC:
                begin
                    if (take)
                    begin
                        if (crcCnt_q != 2'h2)
                        begin
                            phyData_q  <= crcCnt_q[0] ? crc_q[15:8] : crc_q[7:0];
                            phyValid_q <= 1'b1;
                            crcCnt_q   <= crcCnt_q + 2'h1;
                        end
                        else
                        begin
                            phyValid_q <= 1'b0;
                            state_q    <= S_DONE;
                        end
                    end
                end
                S_DONE:
                begin
                    phyIrq_q <= 1'b1;                                       // [R9]
                    state_q  <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
            // after the sequencer so a request landing in the start cycle is kept, not cleared
            if (wrEn && addr == `ADDR_PHY_COMMAND && wrData[`CMD_TX_REQ_BIT])
            begin
                txReq_q  <= 1'b1;                                           // [R4]
                encReq_q <= wrData[`CMD_ENCRYPT_BIT];
            end
        end
    end

    // auto-address takes the base from the read pointer and the length from the buffer byte at cipherAddr, otherwise software base and length
    assign cipherBase   = ctrl_q[`CTRL_AUTOADDR_BIT] ? rdIdx[7:0] : cipherBaseSw;  // [R14]
    assign cipherLen    = ctrl_q[`CTRL_AUTOADDR_BIT] ? peekData : cipherLenSw;     // [R14]
    assign cipherKeySel = keySelectIn;                                             // [R20]
    assign cipherStart  = cipherStart_q;                                           // [R19]
    assign cipherRdData = peekData;
    assign rdData       = rdData_q;
    assign phyData      = phyData_q;
    assign phyValid     = phyValid_q;
    assign aesIrq       = aesIrq_q;
    assign phyIrq       = phyIrq_q;
    assign txBusy       = (state_q != S_IDLE);
endmodule

// ### mac_tx_fifo_ctrl_asserts.sv
// port checks for the transmit buffer controller
`timescale 1ns/1ps
module mac_tx_fifo_ctrl_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] addr,
    input wire logic        wrEn,
    input wire logic        rdEn,
    input wire logic [7:0]  rdData,
    input wire logic [1:0]  registerBankSelect,
    input wire logic        cipherStart,
    input wire logic        cipherDone,
    input wire logic [7:0]  phyData,
    input wire logic        phyValid,
    input wire logic        phyReady,
    input wire logic        aesIrq,
    input wire logic        phyIrq,
    input wire logic        txBusy,
    input wire logic [8:0]  secureCount
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_stream_holds: assert property (phyValid && !phyReady |=> phyValid && $stable(phyData))
        else $error("phy byte dropped before accept");
    a_idle_silent: assert property (!txBusy |-> !phyValid)
        else $error("phy byte while idle");
    a_phy_irq_end: assert property (phyIrq |-> (!txBusy && !phyValid) ##1 !phyIrq)
        else $error("phy interrupt not a closing pulse");
    a_aes_cause: assert property (aesIrq |-> $past(cipherDone) || $past(cipherDone, 2))
        else $error("cipher interrupt without done");
    a_start_pulse: assert property (cipherStart |=> !cipherStart)
        else $error("cipher start longer than a pulse");
    a_bank_hides: assert property (
        rdEn && registerBankSelect != 2'h0 && addr > 16'h2000 && addr < 16'h2006 |=> rdData == 8'h00)
        else $error("fifo register visible in wrong bank");
    a_read_stands: assert property (!rdEn |=> $stable(rdData))
        else $error("read data changed without a read");
    a_secure_push: assert property (
        wrEn && addr == 16'h2000 && registerBankSelect == 2'h1 && secureCount < 9'h100
        |=> secureCount == $past(secureCount) + 9'h001)
        else $error("secure push not counted");
endmodule
bind mac_tx_fifo_ctrl mac_tx_fifo_ctrl_asserts i_chk (.clk(clk), .nrst(nrst), .addr(addr), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .registerBankSelect(registerBankSelect), .cipherStart(cipherStart),
    .cipherDone(cipherDone), .phyData(phyData), .phyValid(phyValid), .phyReady(phyReady), .aesIrq(aesIrq),
    .phyIrq(phyIrq), .txBusy(txBusy), .secureCount(secureCount));

// ### phy_tx_model.sv
// phy transmitter model: takes bytes, optionally slowly, and records them
`timescale 1ns/1ps
module phy_tx_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] phyData,
    input  wire logic       phyValid,
    input  wire logic       stall,
    output logic            phyReady
);
    logic [7:0] got[$];
    logic [1:0] tick;
    // slow mode accepts one cycle in four so the hold of a waiting byte gets exercised
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            tick     <= 2'h0;
            phyReady <= 1'b0;
        end
        else
        begin
            tick     <= tick + 2'h1;
            phyReady <= !stall || tick == 2'h3;
            if (phyValid && phyReady)
                got.push_back(phyData);
        end
    end
endmodule

// ### tb_top.sv
// self-checking bench for the transmit buffer controller
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [1:0] bank; logic wr; logic [15:0] a; logic [7:0] d;} row_t;
    logic        clk = 1'b0, nrst = 1'b0, wrEn = 1'b0, rdEn = 1'b0, autoCrc = 1'b0, keySelectIn = 1'b0;
    logic        cipherDone = 1'b0, stall = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wrData = 8'h00, cipherNewLen = 8'h00, cipherAddr = 8'h00;
    logic [1:0]  registerBankSelect = 2'h0;
    logic [7:0]  rdData, phyData, cipherBase, cipherLen, cipherRdData;
    logic        phyValid, phyReady, cipherStart, aesIrq, phyIrq, cipherKeySel;
    logic [8:0]  secureCount;
    logic [15:0] crc;
    logic [7:0]  expQ[$];
    int          n_mismatch = 0, compares = 0, nPhy = 0, nAes = 0, nStart = 0, base;
    row_t        rows[10];

    mac_tx_fifo_ctrl i_mac_tx_fifo_ctrl (.clk(clk), .nrst(nrst), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
        .wrData(wrData), .rdData(rdData), .registerBankSelect(registerBankSelect), .autoCrc(autoCrc),
        .keySelectIn(keySelectIn), .cipherBaseSw(8'h5A), .cipherLenSw(8'h07), .cipherStart(cipherStart),
        .cipherBase(cipherBase), .cipherLen(cipherLen), .cipherKeySel(cipherKeySel), .cipherDone(cipherDone),
        .cipherNewLen(cipherNewLen), .cipherWe(1'b0), .cipherAddr(cipherAddr), .cipherWrData(8'h00),
        .cipherRdData(cipherRdData), .phyData(phyData), .phyValid(phyValid), .phyReady(phyReady), .aesIrq(aesIrq),
        .phyIrq(phyIrq), .txBusy(), .secureCount(secureCount));
    phy_tx_model i_phy_tx_model (.clk(clk), .nrst(nrst), .phyData(phyData), .phyValid(phyValid),
        .stall(stall), .phyReady(phyReady));

    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (phyIrq === 1'b1)
            nPhy++;
        if (aesIrq === 1'b1)
            nAes++;
        if (cipherStart === 1'b1)
            nStart++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one strobe per access; read data is settled at the falling edge after it
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr   = a;
        wrData = d;
        wrEn   = w;
        rdEn   = !w;
        @(negedge clk);
        wrEn = 1'b0;
        rdEn = 1'b0;
    endtask

    task automatic load(input logic [7:0] b[$]);
        bus(1'b1, 16'h2003, 8'h07);
        bus(1'b1, 16'h2003, 8'h06);
        i_phy_tx_model.got.delete();
        base = nPhy;
        foreach (b[i]) bus(1'b1, 16'h2000, b[i]);
    endtask

    task automatic finish_frame;
        for (int k = 0; k < 600 && nPhy == base; k++)
            @(negedge clk);
        check(16'(nPhy - base), 16'h0001);
        check(16'(i_phy_tx_model.got.size()), 16'(expQ.size()));
        foreach (expQ[i]) check(i_phy_tx_model.got[i], expQ[i]);
        $display("frame test done");
    endtask

    // the length byte is left out of the checksum, hence the start at one
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 1; i < b.size(); i++)
        begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return c;
    endfunction

    task automatic stop_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #800000;
        n_mismatch++;
        stop_test;
    end

    initial
    begin
        rows = '{'{0, 0, 16'h2003, 8'h06}, '{0, 0, 16'h2004, 8'h01}, '{0, 1, 16'h2000, 8'hAA},
            '{0, 0, 16'h2005, 8'h01}, '{0, 0, 16'h2001, 8'h01}, '{0, 0, 16'h2300, 8'hAA},
            '{0, 1, 16'h2301, 8'h55}, '{0, 0, 16'h2301, 8'h55}, '{1, 0, 16'h2005, 8'h00},
            '{1, 1, 16'h2000, 8'h77}};
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        foreach (rows[i])
        begin
            registerBankSelect = rows[i].bank;
            bus(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                check(rdData, rows[i].d);
        end
        registerBankSelect = 2'h0;
        check(secureCount, 9'h001);
        bus(1'b0, 16'h2005, 8'h00);
        check(rdData, 8'h01);
        $display("register rows done");
        load('{});
        for (int i = 0; i < 256; i++)
            bus(1'b1, 16'h2000, i[7:0]);
        bus(1'b1, 16'h2000, 8'hEE);
        bus(1'b0, 16'h2004, 8'h00);
        check(rdData, 8'h82);
        bus(1'b0, 16'h2300, 8'h00);
        check(rdData, 8'h00);
        bus(1'b1, 16'h2004, 8'h00);
        bus(1'b1, 16'h2001, 8'h10);
        bus(1'b1, 16'h2002, 8'h04);
        bus(1'b0, 16'h2005, 8'h00);
        check(rdData, 8'h0C);
        $display("full test done");
        bus(1'b1, 16'h2003, 8'h07);
        bus(1'b0, 16'h2004, 8'h00);
        check(rdData, 8'h01);
        bus(1'b1, 16'h2003, 8'h04);
        bus(1'b1, 16'h2000, 8'h12);
        bus(1'b0, 16'h2005, 8'h00);
        check(rdData, 8'h00);
        bus(1'b1, 16'h2003, 8'h02);
        check(cipherBase, 8'h5A);
        check(cipherLen, 8'h07);
        @(negedge clk) nrst = 1'b0;
        @(negedge clk) nrst = 1'b1;
        bus(1'b0, 16'h2003, 8'h00);
        check(rdData, 8'h06);
        $display("control and reset test done");
        stall = 1'b1;
        expQ = '{8'h03, 8'h11, 8'h22, 8'h33};
        load(expQ);
        bus(1'b1, 16'h2200, 8'h01);
        finish_frame;
        bus(1'b0, 16'h2002, 8'h00);
        check(rdData, 8'h04);
        autoCrc = 1'b1;
        expQ = '{8'h04, 8'hA5, 8'h3C};
        load(expQ);
        crc = crc16(expQ);
        expQ.push_back(crc[7:0]);
        expQ.push_back(crc[15:8]);
        bus(1'b1, 16'h2200, 8'h01);
        finish_frame;
        autoCrc = 1'b0;
        keySelectIn = 1'b1;
        expQ = '{8'h02, 8'h05, 8'h06};
        load(expQ);
        bus(1'b1, 16'h2200, 8'h03);
        for (int k = 0; k < 50 && nStart == 0; k++)
            @(negedge clk);
        check(cipherBase, 8'h00);
        check(cipherLen, 8'h02);
        check(cipherRdData, 8'h02);
        check(cipherKeySel, 1'b1);
        check(16'(nStart), 16'h0001);
        cipherNewLen = 8'h01;
        cipherDone = 1'b1;
        @(negedge clk) cipherDone = 1'b0;
        @(negedge clk);
        expQ = '{8'h01, 8'h05};
        finish_frame;
        check(nAes[15:0], 16'h0001);
        stop_test;
    end
endmodule
